/* File: bench/himu_evt_src.sv */
// Event register model feeding latched event bits
module himu_evt_src (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Requested events and the latched result
    input wire logic [31:0] want_bits,
    output logic [31:0] event_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latch one cycle late, each event at its own position
    always_ff @(posedge clk_sys)
    begin
        event_bits <= reset ? 32'h0000_0000 : want_bits;
    end
endmodule : himu_evt_src

/* File: bench/himu_props.sv */
// Port checks of the interrupt mask unit
module himu_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus, events, mask and interrupt
    input wire himu_pkg::himu_wb_req_s wb_req,
    input wire himu_pkg::himu_wb_rsp_s wb_rsp,
    input wire logic [31:0] event_bits,
    input wire logic [31:0] mask_bits,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic hit, wr, rd_reg, set_ack, clr_ack;
    logic [31:0] wd;
    // Decoded bus phases and the gated source sum
    assign hit = mask_bits[31] & |(event_bits & mask_bits
        & himu_pkg::SOURCE_BITS);
    assign wd = wb_req.dat & himu_pkg::MASK_WRITABLE;
    assign wr = wb_rsp.ack && wb_req.we && wb_req.sel == 4'hF;
    assign set_ack = wr && wb_req.adr == himu_pkg::OFS_ENABLE_SET;
    assign clr_ack = wr && wb_req.adr == himu_pkg::OFS_ENABLE_CLEAR;
    assign rd_reg = wb_rsp.ack && !wb_req.we
        && wb_req.adr[11:3] == himu_pkg::OFS_ENABLE_SET[11:3];
    property p_irq; irq == $past(hit); endproperty
    property p_off; !mask_bits[31] |=> !irq; endproperty
    property p_r28; mask_bits[28] == 1'b0; endproperty
    property p_r14; mask_bits[14:10] == 5'h0; endproperty
    property p_rd; rd_reg |-> wb_rsp.dat == $past(mask_bits); endproperty
    property p_set; set_ack |=> (mask_bits & $past(wd)) == $past(wd);
    endproperty
    property p_clr; clr_ack |=> (mask_bits & $past(wd)) == 32'h0000_0000;
    endproperty
    property p_ans; wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
    endproperty
    property p_drop; wb_rsp.ack |=> !wb_rsp.ack; endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");
    a_off: assert property (p_off) else $error("irq ungated");
    a_r28: assert property (p_r28) else $error("bit 28 set");
    a_r14: assert property (p_r14) else $error("bits 14-10 set");
    a_rd: assert property (p_rd) else $error("read data");
    a_set: assert property (p_set) else $error("set lost");
    a_clr: assert property (p_clr) else $error("clear lost");
    a_ans: assert property (p_ans) else $error("no ack");
    a_drop: assert property (p_drop) else $error("ack long");
    // Main scenarios
    c_irq: cover property ($rose(irq));
    c_set: cover property (set_ack);
    c_clr: cover property (clr_ack);
endmodule : himu_props

bind himu_top himu_props himu_props_inst (.clk_sys(clk_sys),
    .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .event_bits(event_bits), .mask_bits(mask_bits), .irq(irq));

/* File: bench/testbench.sv */
// Self-checking bench of the interrupt mask unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] SET = himu_pkg::OFS_ENABLE_SET;
    localparam logic [11:0] CLR = himu_pkg::OFS_ENABLE_CLEAR;
    localparam logic [31:0] W = himu_pkg::MASK_WRITABLE;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    himu_pkg::himu_wb_req_s req = '0;
    himu_pkg::himu_wb_rsp_s rsp;
    logic [31:0] want = 32'h0000_0000;
    logic [31:0] evt, mask, rd;
    logic irq;
    int err_count = 0;
    int num_checks = 0;
    int cyc_n = 0;
    `define CHK(a, e) chk(a, e)
    always #2.5 clk_sys = ~clk_sys;
    himu_top himu_top_inst (.clk_sys(clk_sys), .reset(reset),
        .wb_req(req), .wb_rsp(rsp), .event_bits(evt), .mask_bits(mask),
        .irq(irq));
    himu_evt_src himu_evt_src_inst (.clk_sys(clk_sys), .reset(reset),
        .want_bits(want), .event_bits(evt));
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        num_checks++;
        if (a !== e)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, a, e);
        end
    endtask : chk
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
        @(posedge clk_sys);
        while (rsp.ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(rsp.ack, 1'b1);
        r = rsp.dat;
        req <= '0;
        @(posedge clk_sys);
    endtask : wb
    task automatic summarize();
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc_n++;
        if (cyc_n > 5000)
        begin
            err_count++;
            summarize();
        end
    end
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        wb(1'b0, SET, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, himu_pkg::MASK_RESET);
        wb(1'b1, SET, 32'hFFFF_FFFF, 4'hF, rd);
        wb(1'b1, CLR, 32'h0000_0000, 4'hF, rd);
        wb(1'b0, CLR, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, W);
        `CHK(mask, W);
        wb(1'b1, CLR, 32'hFFFF_FFFF, 4'h1, rd);
        wb(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF, rd);
        wb(1'b1, himu_pkg::OFS_PENDING, 32'hFFFF_FFFF, 4'hF, rd);
        wb(1'b0, 12'h100, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, himu_pkg::READ_UNMAPPED);
        wb(1'b0, SET, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, W & 32'hFFFF_FF00);
        wb(1'b1, SET, 32'h0000_00FF, 4'hF, rd);
        wb(1'b1, CLR, 32'h8000_0000, 4'hF, rd);
        want <= 32'hFFFF_FFFF;
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0);
        wb(1'b1, SET, 32'h8000_0000, 4'hF, rd);
        // Each source alone: fires with its mask, quiet without
        for (int i = 0; i < 32; i++)
        begin
            if (himu_pkg::SOURCE_BITS[i])
            begin
                want <= 32'h0000_0001 << i;
                repeat (3) @(posedge clk_sys);
                `CHK(irq, 1'b1);
                // Pending view shows only the one gated source
                wb(1'b0, himu_pkg::OFS_PENDING, 32'h0000_0000, 4'hF, rd);
                `CHK(rd, 32'h0000_0001 << i);
                wb(1'b1, CLR, 32'h0000_0001 << i, 4'hF, rd);
                repeat (2) @(posedge clk_sys);
                `CHK(irq, 1'b0);
                wb(1'b1, SET, 32'h0000_0001 << i, 4'hF, rd);
            end
        end
        // Mid-run reset returns the mask and the output to rest
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        `CHK(irq, 1'b0);
        `CHK(mask, himu_pkg::MASK_RESET);
        wb(1'b0, CLR, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, himu_pkg::MASK_RESET);
        summarize();
    end
endmodule : testbench

/* File: rtl/himu_pkg.sv */
// Constants and carrier types of the host interrupt mask unit
package himu_pkg;

    // Data and address widths of the register bus
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned LANE_W = 8;

    // Register byte addresses
    localparam logic [11:0] OFS_ENABLE_SET = 12'h088;
    localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h08C;
    localparam logic [11:0] OFS_PENDING = 12'h0C0;

    // Word-select bits of the address
    localparam int unsigned WORD_LSB = 2;

    // Mask field positions
    localparam int unsigned POS_GLOBAL_GATE = 31;
    localparam int unsigned POS_MAKER = 30;
    localparam int unsigned POS_SOFTWARE = 29;
    localparam int unsigned POS_RSVD_HI = 28;
    localparam int unsigned POS_TARDY_ACK = 27;
    localparam int unsigned POS_LINK_REG = 26;
    localparam int unsigned POS_OVERLONG = 25;
    localparam int unsigned POS_FATAL = 24;
    localparam int unsigned POS_CYCLE_HI = 23;
    localparam int unsigned POS_CYCLE_LO = 20;
    localparam int unsigned POS_BUSMGT_HI = 19;
    localparam int unsigned POS_BUSMGT_LO = 15;
    localparam int unsigned POS_RSVD_LO_HI = 14;
    localparam int unsigned POS_RSVD_LO_LO = 10;
    localparam int unsigned POS_ERR_HI = 9;
    localparam int unsigned POS_ERR_LO = 8;
    localparam int unsigned POS_TIMED_HI = 7;
    localparam int unsigned POS_TIMED_LO = 6;
    localparam int unsigned POS_ASYNC_HI = 5;
    localparam int unsigned POS_ASYNC_LO = 0;

    // Bits that software can change; reserved bits stay zero
    localparam logic [31:0] MASK_WRITABLE = 32'hEFFF_83FF;

    // Bits that name a source; the global gate is not a source
    localparam logic [31:0] SOURCE_BITS = 32'h6FFF_83FF;

    // Reset value of the mask
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Read value of unmapped addresses
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // Wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } himu_wb_req_s;

    // Wishbone answer carrier
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } himu_wb_rsp_s;

    // Whole state of the unit
    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] rdata;
        logic ack;
        logic irq;
    } himu_state_s;

endpackage : himu_pkg

/* File: rtl/himu_top.sv */
// Interrupt mask register with set and clear views and the gated output
module himu_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone slave request and answer
    input wire himu_pkg::himu_wb_req_s wb_req,
    output himu_pkg::himu_wb_rsp_s wb_rsp,
    // Latched event bits from the event register
    input wire logic [31:0] event_bits,
    // Mask contents for neighbouring logic
    output logic [31:0] mask_bits,
    // External interrupt request
    output logic irq
);

    // Byte-lane select expanded to a bit mask
    function automatic logic [31:0] lane_bits(
        input logic [3:0] sel
    );
        logic [31:0] bits;
        bits = 32'h0000_0000;
        for (int i = 0; i < himu_pkg::SEL_W; i++)
        begin
            bits[i * himu_pkg::LANE_W +: himu_pkg::LANE_W] = {
                himu_pkg::LANE_W{sel[i]}};
        end
        return bits;
    endfunction : lane_bits

    // Word match of an address against a register offset
    function automatic logic hits(
        input logic [11:0] adr,
        input logic [11:0] ofs
    );
        return adr[11:himu_pkg::WORD_LSB] == ofs[11:himu_pkg::WORD_LSB];
    endfunction : hits

    himu_pkg::himu_state_s st_q;
    himu_pkg::himu_state_s st_d;

    logic req_live;
    logic hit_set;
    logic hit_clear;
    logic hit_pending;
    logic [31:0] wr_bits;
    logic [31:0] pair_bits;
    logic [31:0] src_hit;
    logic maker_hit;
    logic software_hit;
    logic tardy_hit;
    logic link_reg_hit;
    logic overlong_hit;
    logic fatal_hit;
    logic cycle_hit;
    logic busmgt_hit;
    logic err_hit;
    logic timed_hit;
    logic async_hit;
    logic any_source;

    // Bus request decode
    assign req_live = wb_req.cyc & wb_req.stb;
    assign hit_set = hits(wb_req.adr, himu_pkg::OFS_ENABLE_SET);
    assign hit_clear = hits(wb_req.adr, himu_pkg::OFS_ENABLE_CLEAR);
    assign hit_pending = hits(wb_req.adr, himu_pkg::OFS_PENDING);

    // Bits a write touches: written ones in enabled lanes, reserved masked
    assign wr_bits = wb_req.dat & lane_bits(wb_req.sel)
        & himu_pkg::MASK_WRITABLE;

    // Each source pairs its event bit with the mask bit at its position
    genvar g;
    generate
        for (g = 0; g < himu_pkg::DATA_W; g++)
        begin : g_pair
            assign pair_bits[g] = event_bits[g] & st_q.mask[g]
                & himu_pkg::SOURCE_BITS[g];
        end
    endgenerate

    // Per-source enables, grouped by source kind
    assign maker_hit = pair_bits[himu_pkg::POS_MAKER];
    assign software_hit = pair_bits[himu_pkg::POS_SOFTWARE];
    assign tardy_hit = pair_bits[himu_pkg::POS_TARDY_ACK];
    assign link_reg_hit = pair_bits[himu_pkg::POS_LINK_REG];
    assign overlong_hit = pair_bits[himu_pkg::POS_OVERLONG];
    assign fatal_hit = pair_bits[himu_pkg::POS_FATAL];
    assign cycle_hit = |pair_bits[himu_pkg::POS_CYCLE_HI:
        himu_pkg::POS_CYCLE_LO];
    assign busmgt_hit = |pair_bits[himu_pkg::POS_BUSMGT_HI:
        himu_pkg::POS_BUSMGT_LO];
    assign err_hit = |pair_bits[himu_pkg::POS_ERR_HI:
        himu_pkg::POS_ERR_LO];
    assign timed_hit = |pair_bits[himu_pkg::POS_TIMED_HI:
        himu_pkg::POS_TIMED_LO];
    assign async_hit = |pair_bits[himu_pkg::POS_ASYNC_HI:
        himu_pkg::POS_ASYNC_LO];

    // Collected view of the individual source enables
    assign src_hit = pair_bits;
    assign any_source = maker_hit | software_hit | tardy_hit
        | link_reg_hit | overlong_hit | fatal_hit | cycle_hit
        | busmgt_hit | err_hit | timed_hit | async_hit;

    // Next state: ack, read data, mask update and interrupt
    always_comb
    begin
        st_d = st_q;
        // Answer one cycle after the request, drop it a cycle later
        st_d.ack = req_live & ~st_q.ack;
        // Read data prepared together with the ack
        if (req_live & ~st_q.ack)
        begin
            if (hit_set | hit_clear)
            begin
                st_d.rdata = st_q.mask;
            end
            else if (hit_pending)
            begin
                st_d.rdata = src_hit & {32{st_q.mask[
                    himu_pkg::POS_GLOBAL_GATE]}};
            end
            else
            begin
                st_d.rdata = himu_pkg::READ_UNMAPPED;
            end
        end
        // Write takes effect at the edge where the master sees ack
        if (req_live & st_q.ack & wb_req.we)
        begin
            if (hit_set)
            begin
                st_d.mask = st_q.mask | wr_bits;
            end
            else if (hit_clear)
            begin
                st_d.mask = st_q.mask & ~wr_bits;
            end
        end
        // Global gate over the OR of all source pairs
        st_d.irq = st_q.mask[himu_pkg::POS_GLOBAL_GATE]
            & any_source;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_q.mask <= himu_pkg::MASK_RESET;
            st_q.rdata <= himu_pkg::READ_UNMAPPED;
            st_q.ack <= 1'b0;
            st_q.irq <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_rsp.ack = st_q.ack;
    assign wb_rsp.dat = st_q.rdata;
    assign mask_bits = st_q.mask;
    assign irq = st_q.irq;

endmodule : himu_top
